/* rtl/oc_power_pkg.sv */
// constants and register layout for the output compare channel
package oc_power_pkg;
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADDR_SEC_CMP = 8'h08;
  localparam logic [7:0] ADDR_PRI_CMP = 8'h0C;
  localparam logic [7:0] ADDR_TMR = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [15:0] CTRL_ONE_RESET = 16'h0000;
  localparam logic [15:0] CTRL_TWO_RESET = 16'h000C;
  localparam logic [15:0] CTRL_ONE_MASK = 16'h3FFF;
  localparam logic [15:0] CTRL_TWO_MASK = 16'hF7FF;
  // control one fields
  localparam int C1_IDLE_STOP = 13;
  localparam int C1_TSEL_LO = 10;
  localparam int C1_FEN_LO = 7;
  localparam int C1_FFLAG_LO = 4;
  localparam int C1_ONE_SHOT = 3;
  localparam int C1_MODE_LO = 0;
  // control two fields
  localparam int C2_FAULT_CLR_MODE = 15;
  localparam int C2_FAULT_OUT = 14;
  localparam int C2_FAULT_TRI = 13;
  localparam int C2_INVERT = 12;
  localparam int C2_TRIG_SEL = 7;
  localparam int C2_TRIG_STAT = 6;
  localparam int C2_OUT_TRI = 5;
  // interrupt status bits
  localparam int IRQ_MATCH = 0;
  localparam int IRQ_FAULT = 1;
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_FAULT_PWM = 3'h7;
  typedef enum logic [1:0] {PWR_RUN, PWR_IDLE, PWR_SLEEP, PWR_DOZE} power_state_t;
endpackage

/* rtl/fault_sync.sv */
// two-flop synchroniser for the fault pins
`timescale 1ns/1ps
`default_nettype none
module fault_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_q <= '0;
      sync_out <= '0;
    end else begin
      stage1_q <= async_in;
      sync_out <= stage1_q;
    end
  end
endmodule
`default_nettype wire

/* rtl/output_compare_power_pin_ctrl.sv */
// output compare channel with power states, fault forcing, pin ownership and apb registers
`timescale 1ns/1ps
`default_nettype none
module output_compare_power_pin_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire oc_power_pkg::power_state_t power_state,
  input wire logic peripheral_module_disable,
  input wire logic [5:0] timebase_tick,
  input wire logic trigger_in,
  input wire logic [2:0] fault_pins_in,
  input wire logic pin_latch,
  input wire logic pin_direction,
  output logic compare_output_pin,
  output logic compare_output_pin_oe,
  output logic irq
);
  import oc_power_pkg::*;

  logic [15:0] ctrl_one_q;
  logic [15:0] ctrl_two_q;
  logic [15:0] sec_cmp_q;
  logic [15:0] pri_cmp_q;
  logic [15:0] tmr_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic [1:0] irq_pending_q;
  logic out_level_q;
  logic fault_force_q;
  logic [2:0] fault_sync;
  logic [2:0] fault_hit;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic halted;
  logic sleeping;
  logic enabled;
  logic tick;
  logic timer_held;
  logic match_pri;
  logic match_sec;
  logic [15:0] ctrl_one_wr;

  fault_sync #(.WIDTH(3)) u_fault_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(fault_pins_in),
    .sync_out(fault_sync)
  );

  assign addr_ok = (paddr == ADDR_CTRL_ONE) || (paddr == ADDR_CTRL_TWO) || (paddr == ADDR_SEC_CMP)
                 || (paddr == ADDR_PRI_CMP) || (paddr == ADDR_TMR) || (paddr == ADDR_IRQ_STAT)
                 || (paddr == ADDR_IRQ_MASK);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  // module disable blocks every register write
  assign wr_en = psel && penable && pwrite && !peripheral_module_disable;
  assign rd_en = psel && penable && !pwrite;

  assign sleeping = (power_state == PWR_SLEEP);
  // doze is treated the same as run
  assign halted = sleeping || ((power_state == PWR_IDLE) && ctrl_one_q[C1_IDLE_STOP])
                  || peripheral_module_disable;
  assign enabled = (ctrl_one_q[C1_MODE_LO +: 3] != MODE_OFF);
  assign tick = timebase_tick[ctrl_one_q[C1_TSEL_LO +: 3] > 3'h5 ? 3'h5 : ctrl_one_q[C1_TSEL_LO +: 3]];
  assign timer_held = ctrl_one_q[C1_ONE_SHOT] && !ctrl_two_q[C2_TRIG_STAT];
  assign match_pri = enabled && !halted && tick && !timer_held && (tmr_q == pri_cmp_q);
  assign match_sec = enabled && !halted && tick && !timer_held && (tmr_q == sec_cmp_q);
  // fault detection keeps running in every power state, only in fault pwm mode
  assign fault_hit = fault_sync & ctrl_one_q[C1_FEN_LO +: 3]
                     & {3{ctrl_one_q[C1_MODE_LO +: 3] == MODE_FAULT_PWM}};

  // flags: hardware set wins over a software write of zero
  always_comb begin
    ctrl_one_wr = (pwdata[15:0] & CTRL_ONE_MASK);
    ctrl_one_wr[C1_FFLAG_LO +: 3] = ctrl_one_wr[C1_FFLAG_LO +: 3] | fault_hit;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_one_q <= CTRL_ONE_RESET;
    end else if (wr_en && paddr == ADDR_CTRL_ONE) begin
      ctrl_one_q <= ctrl_one_wr;
    end else begin
      ctrl_one_q[C1_FFLAG_LO +: 3] <= ctrl_one_q[C1_FFLAG_LO +: 3] | fault_hit;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_two_q <= CTRL_TWO_RESET;
    end else if (wr_en && paddr == ADDR_CTRL_TWO) begin
      ctrl_two_q <= pwdata[15:0] & CTRL_TWO_MASK;
      if (trigger_in && !halted) begin
        ctrl_two_q[C2_TRIG_STAT] <= 1'b1;
      end
    end else if (!halted) begin
      if (trigger_in) begin
        ctrl_two_q[C2_TRIG_STAT] <= 1'b1;
      end else if (ctrl_one_q[C1_ONE_SHOT] && tick && tmr_q == sec_cmp_q) begin
        ctrl_two_q[C2_TRIG_STAT] <= 1'b0;
      end
    end
  end

  // compare values have no reset; they hold across halt so wake needs no setup
  always_ff @(posedge clk) begin
    if (wr_en && paddr == ADDR_SEC_CMP) begin
      sec_cmp_q <= pwdata[15:0];
    end
    if (wr_en && paddr == ADDR_PRI_CMP) begin
      pri_cmp_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (wr_en && paddr == ADDR_TMR) begin
      tmr_q <= pwdata[15:0];
    end else if (enabled && timer_held && !halted) begin
      tmr_q <= 16'h0000;
    end else if (enabled && !halted && tick) begin
      tmr_q <= (tmr_q == sec_cmp_q) ? 16'h0000 : tmr_q + 16'h0001;
    end
  end

  // pwm-style output: set at period rollover, clear at primary match
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_level_q <= 1'b0;
    end else if (!enabled) begin
      out_level_q <= 1'b0;
    end else if (!halted) begin
      if (match_sec) begin
        out_level_q <= 1'b1;
      end else if (match_pri) begin
        out_level_q <= 1'b0;
      end
    end
  end

  // fault latch: released by software clearing the flags, or by the period when automatic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_force_q <= 1'b0;
    end else if (|fault_hit) begin
      fault_force_q <= 1'b1;
    end else if (ctrl_two_q[C2_FAULT_CLR_MODE]) begin
      if (ctrl_one_q[C1_FFLAG_LO +: 3] == 3'h0) begin
        fault_force_q <= 1'b0;
      end
    end else if (match_sec) begin
      fault_force_q <= 1'b0;
    end
  end

  always_comb begin
    compare_output_pin = pin_latch;
    compare_output_pin_oe = !pin_direction;
    if (enabled) begin
      compare_output_pin_oe = !ctrl_two_q[C2_OUT_TRI];
      compare_output_pin = out_level_q ^ ctrl_two_q[C2_INVERT];
      if (fault_force_q) begin
        compare_output_pin = ctrl_two_q[C2_FAULT_OUT];
        compare_output_pin_oe = !ctrl_two_q[C2_FAULT_TRI];
      end
    end
  end

  // interrupts: events latch into pending while asleep and post on wake
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_pending_q <= 2'h0;
    end else if (sleeping) begin
      irq_pending_q <= irq_pending_q | {|fault_hit, 1'b0};
    end else begin
      irq_pending_q <= 2'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= 2'h0;
    end else begin
      if (wr_en && paddr == ADDR_IRQ_STAT) begin
        // a queued sleep event posting in the same cycle as a clear still wins
        irq_stat_q <= (irq_stat_q & ~pwdata[1:0]) | (sleeping ? 2'h0 : (irq_pending_q | {|fault_hit, match_pri}));
      end else if (!sleeping) begin
        irq_stat_q <= irq_stat_q | irq_pending_q | {|fault_hit, match_pri};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_q <= 2'h0;
    end else if (wr_en && paddr == ADDR_IRQ_MASK) begin
      irq_mask_q <= pwdata[1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h00000000;
      if (!peripheral_module_disable) begin
        case (paddr)
          ADDR_CTRL_ONE: prdata <= {16'h0000, ctrl_one_q};
          ADDR_CTRL_TWO: prdata <= {16'h0000, ctrl_two_q};
          ADDR_SEC_CMP: prdata <= {16'h0000, sec_cmp_q};
          ADDR_PRI_CMP: prdata <= {16'h0000, pri_cmp_q};
          ADDR_TMR: prdata <= {16'h0000, tmr_q};
          ADDR_IRQ_STAT: prdata <= {30'h00000000, irq_stat_q};
          ADDR_IRQ_MASK: prdata <= {30'h00000000, irq_mask_q};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  logic unused_ok;
  assign unused_ok = rd_en;
endmodule
`default_nettype wire

/* testbench/oc_pin_monitor.sv */
// port checker for the output compare channel
`timescale 1ns/1ps
`default_nettype none
module oc_pin_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire oc_power_pkg::power_state_t power_state,
  input wire logic peripheral_module_disable,
  input wire logic [2:0] fault_pins_in,
  input wire logic pin_latch,
  input wire logic pin_direction,
  input wire logic compare_output_pin,
  input wire logic compare_output_pin_oe,
  input wire logic irq
);
  import oc_power_pkg::*;
  logic [15:0] c1_q;
  logic [15:0] c2_q;
  logic [2:0] md;
  assign md = c1_q[2:0];
  // shadow of the control words, since the body is out of sight
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      c1_q <= CTRL_ONE_RESET;
      c2_q <= CTRL_TWO_RESET;
    end else if (psel && penable && pwrite && !peripheral_module_disable) begin
      if (paddr == ADDR_CTRL_ONE) c1_q <= pwdata[15:0];
      if (paddr == ADDR_CTRL_TWO) c2_q <= pwdata[15:0];
    end
  end
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_sleep_hold;
    (power_state == PWR_SLEEP && md != MODE_OFF && md != MODE_FAULT_PWM) ##1 power_state == PWR_SLEEP
      |-> $stable(compare_output_pin);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("pin moved while asleep");
  property p_sleep_irq;
    power_state == PWR_SLEEP ##1 power_state == PWR_SLEEP |-> !$rose(irq);
  endproperty
  a_sleep_irq: assert property (p_sleep_irq) else $error("interrupt raised while asleep");
  property p_fault_pin;
    (md == MODE_FAULT_PWM && !c2_q[C2_FAULT_TRI] && !c2_q[C2_INVERT] && !peripheral_module_disable
      && (fault_pins_in & c1_q[9:7]) != 3'h0) [*4] |-> compare_output_pin == c2_q[C2_FAULT_OUT];
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("fault did not force the pin");
  property p_gpio;
    md == MODE_OFF |-> compare_output_pin == pin_latch && compare_output_pin_oe == !pin_direction;
  endproperty
  a_gpio: assert property (p_gpio) else $error("pin not handed back to latch");
  property p_own;
    md != MODE_OFF && md != MODE_FAULT_PWM && !c2_q[C2_OUT_TRI] && !peripheral_module_disable
      |-> compare_output_pin_oe;
  endproperty
  a_own: assert property (p_own) else $error("enabled channel not driving pin");
  property p_pmd_rd;
    peripheral_module_disable && psel && !penable && !pwrite |=> prdata == 32'h0;
  endproperty
  a_pmd_rd: assert property (p_pmd_rd) else $error("gated read not zero");
  property p_ctrl_rd;
    psel && !penable && !pwrite && paddr == ADDR_CTRL_ONE |=> prdata[31:14] == 18'h0;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("unused control bits not zero");
  property p_unmapped;
    psel && penable && paddr > ADDR_IRQ_MASK |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
endmodule
bind output_compare_power_pin_ctrl oc_pin_monitor mon_u (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pslverr, .power_state, .peripheral_module_disable, .fault_pins_in, .pin_latch, .pin_direction,
  .compare_output_pin, .compare_output_pin_oe, .irq);
`default_nettype wire

/* testbench/fault_source.sv */
// far side model: fault sources and the pad with its pull-up
`timescale 1ns/1ps
`default_nettype none
module fault_source (
  input wire logic [2:0] fault_req,
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic [2:0] fault_pins,
  output logic pad_level
);
  assign fault_pins = fault_req;
  // a released pad floats up, so a stale driven level cannot pass
  assign pad_level = pin_oe ? pin_out : 1'b1;
endmodule
`default_nettype wire

/* testbench/output_compare_power_pin_ctrl_bench.sv */
// self-checking bench for the output compare channel
`timescale 1ns/1ps
`default_nettype none
module output_compare_power_pin_ctrl_bench;
  import oc_power_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, peripheral_module_disable = 0, trigger_in = 0;
  logic pin_latch = 0, pin_direction = 1, pready, pslverr, err, irq, compare_output_pin, compare_output_pin_oe, pad;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [15:0] wdat;
  logic [5:0] timebase_tick = 0;
  logic [2:0] fault_req = 0, fault_pins_in;
  power_state_t power_state = PWR_RUN;
  int failures = 0, cmp_count = 0, seed = 32'h68B67A1C;
  output_compare_power_pin_ctrl dut_u (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .power_state, .peripheral_module_disable, .timebase_tick, .trigger_in, .fault_pins_in, .pin_latch,
    .pin_direction, .compare_output_pin, .compare_output_pin_oe, .irq);
  fault_source far_u (.fault_req, .pin_out(compare_output_pin), .pin_oe(compare_output_pin_oe),
    .fault_pins(fault_pins_in), .pad_level(pad));
  always #12.5 clk = ~clk;
  always @(posedge clk) timebase_tick <= 6'($random(seed));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons=%0d mismatches=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      failures++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // counts pin edges over a fixed stretch in one power state
  task automatic watch(input power_state_t s, input int moving);
    int c;
    logic last;
    power_state <= s;
    repeat (2) @(posedge clk);
    last = compare_output_pin;
    c = 0;
    repeat (60) begin
      @(posedge clk);
      c += int'(compare_output_pin !== last);
      last = compare_output_pin;
    end
    chk(32'(c != 0), moving);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(0, ADDR_CTRL_ONE, 0);
    chk(rd, 32'h0000);
    apb(0, ADDR_CTRL_TWO, 0);
    chk(rd, 32'h000C);
    apb(1, ADDR_CTRL_ONE, 32'hBC00);
    apb(0, ADDR_CTRL_ONE, 0);
    chk(rd, 32'h3C00);
    peripheral_module_disable <= 1'b1;
    apb(1, ADDR_CTRL_ONE, 0);
    apb(0, ADDR_CTRL_ONE, 0);
    chk(rd, 32'h0);
    peripheral_module_disable <= 1'b0;
    apb(0, ADDR_CTRL_ONE, 0);
    chk(rd, 32'h3C00);
    apb(0, 8'h1C, 0);
    chk(err, 1);
    repeat (4) begin
      pin_latch <= 1'($random(seed));
      pin_direction <= 1'($random(seed));
      wdat = 16'($random(seed));
      apb(1, ADDR_PRI_CMP, {16'h0, wdat});
      apb(0, ADDR_PRI_CMP, 0);
      chk(rd, {16'h0, wdat});
      chk(pad, pin_direction ? 1'b1 : pin_latch);
    end
    // the timer has no reset value, so it is loaded before counting
    apb(1, ADDR_TMR, 0);
    apb(1, ADDR_SEC_CMP, 8);
    apb(1, ADDR_PRI_CMP, 3);
    apb(1, ADDR_CTRL_ONE, 32'h2006);
    watch(PWR_RUN, 1);
    watch(PWR_SLEEP, 0);
    watch(PWR_RUN, 1);
    watch(PWR_DOZE, 1);
    watch(PWR_IDLE, 0);
    apb(1, ADDR_CTRL_ONE, 32'h0006);
    watch(PWR_IDLE, 1);
    power_state <= PWR_RUN;
    apb(1, ADDR_CTRL_ONE, 32'h000E);
    apb(0, ADDR_TMR, 0);
    chk(rd, 32'h0);
    trigger_in <= 1'b1;
    @(posedge clk);
    trigger_in <= 1'b0;
    apb(0, ADDR_CTRL_TWO, 0);
    chk(rd[6], 1);
    repeat (100) @(posedge clk);
    apb(0, ADDR_CTRL_TWO, 0);
    chk(rd[6], 0);
    apb(1, ADDR_CTRL_TWO, 32'h400C);
    apb(1, ADDR_CTRL_ONE, 32'h0087);
    apb(1, ADDR_IRQ_STAT, 3);
    apb(1, ADDR_IRQ_MASK, 2);
    power_state <= PWR_SLEEP;
    fault_req <= 3'h1;
    repeat (6) @(posedge clk);
    chk(compare_output_pin, 1);
    chk(irq, 0);
    power_state <= PWR_RUN;
    repeat (4) @(posedge clk);
    chk(irq, 1);
    fault_req <= 3'h0;
    apb(0, ADDR_CTRL_ONE, 0);
    chk(rd[4], 1);
    apb(1, ADDR_IRQ_MASK, 0);
    chk(irq, 0);
    apb(1, ADDR_IRQ_STAT, 2);
    apb(1, ADDR_IRQ_MASK, 2);
    chk(irq, 0);
    give_verdict();
  end
endmodule
`default_nettype wire
